// ===== sim/dclc_host_model.sv
// host side model: sends one command register write when the device is idle
`default_nettype none
module dclc_host_model
  import dclc_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // device status
  input wire logic i_busy,
  input wire logic i_drq,
  input wire logic i_ready,
  input wire logic i_queue_empty,
  // bench requests
  input wire logic i_go,
  input wire logic i_break,
  input wire dclc_cmd_t i_cmd,
  input wire logic [15:0] i_act,
  input wire logic [15:0] i_feat,
  // command register write
  output logic o_cmd_wr,
  output dclc_cmd_t o_cmd,
  output logic [15:0] o_act,
  output logic [15:0] o_feat
);
  timeunit 1ns;
  timeprecision 1ps;
  dclc_cmd_t cmd_q;
  logic [15:0] act_q;
  logic [15:0] feat_q;
  logic pend_q;
  // =========================================
  // command issue
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pend_q <= 1'b0;
      cmd_q <= '0;
      act_q <= 16'h0000;
      feat_q <= 16'h0000;
      o_cmd_wr <= 1'b0;
    end else if (i_go) begin
      pend_q <= 1'b1;
      cmd_q <= i_cmd;
      act_q <= i_act;
      feat_q <= i_feat;
      o_cmd_wr <= 1'b0;
    end else if (pend_q && !i_busy && !i_drq && i_ready &&
                 (i_queue_empty || cmd_q.is_queued || i_break)) begin
      pend_q <= 1'b0;
      o_cmd_wr <= 1'b1;
    end else begin
      o_cmd_wr <= 1'b0;
    end
  end
  // outside the write the lines show the inverse, so stale data never matches
  assign o_cmd = o_cmd_wr ? cmd_q : ~cmd_q;
  assign o_act = o_cmd_wr ? act_q : ~act_q;
  assign o_feat = o_cmd_wr ? feat_q : ~feat_q;
endmodule
`default_nettype wire

// ===== sim/test_disk_command_layer_control.sv
// bench for the disk command layer control
`default_nettype none
module test_disk_command_layer_control;
  import dclc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // =========================================
  // stimulus and observation
  localparam dclc_settings_t SV = '{16'h1234, 8'h56, 1'b1, 1'b1, 48'h0000_0000_1000,
                                    1'b1, 8'h45, 1'b1, 1'b1, 1'b0, 8'h10};
  logic [47:0] nm [4] = '{48'h0000_0FFF_FFFE, 48'h0000_0FFF_FFFF, 48'h0000_1000_0000,
                          48'h0001_0000_0000};
  logic [2:0] cfl [4] = '{3'b110, 3'b000, 3'b110, 3'b000};
  logic [15:0] ccn [4] = '{16'h1234, 16'hAB00, 16'hFFFF, 16'h0012};
  logic [7:0] lp [6] = '{8'hE0, 8'hE0, 8'hE0, 8'hE0, 8'hE1, 8'hE0};
  logic [15:0] la [6] = '{16'h0002, 16'h0003, 16'h0004, 16'h0004, 16'h0005, 16'h0006};
  logic [15:0] lf [6] = '{16'h0000, 16'h0000, 16'h0001, 16'h0003, 16'h0000, 16'h0000};
  logic clk = 1'b0, rst = 1'b1, xneed = 1'b0, qemp = 1'b1, go = 1'b0, brk = 1'b0;
  logic [8:0] pl = 9'h000, rlen = 9'h001;
  logic f4k = 1'b0, vok = 1'b1;
  logic [63:0] mlba;
  logic [47:0] nmax = 48'h0000_0010_0000;
  dclc_settings_t sset = '0;
  dclc_cmd_t hcmd = '0;
  dclc_cmd_t cmd;
  dclc_settings_t oset;
  logic [15:0] hact = 16'h0000, hfeat = 16'h0000, act, feat, w83, scnt;
  logic cwr, busy, data_request_flag, rdy, irq, abort, qhalt, pres, lv, ldp, lwc, ltp, rerr, rall, reas;
  logic r, e;
  logic [6:0] le;
  logic [47:0] max28;
  logic [2:0] lsel;
  int err_count = 0, checked = 0, cyc = 0, rc = 0, na = 0, n = 0;

  dclc_top #(.BUSY_CYC(1)) dut (
    .i_sys_clk(clk), .i_rst(rst), .i_link_rst(pl[2]), .i_soft_rst(pl[3]),
    .i_cmd_wr(cwr), .i_cmd(cmd), .i_log_action(act), .i_log_feature(feat),
    .i_status_rd(pl[0]), .i_native_max(nmax), .i_xfer_need(xneed), .i_xfer_done(pl[1]),
    .i_queue_empty(qemp), .i_settings_wr(pl[4]), .i_settings(sset), .i_wr_fail(pl[5]),
    .i_rd_hard_fail(pl[6]), .i_rd_recovered(pl[7]), .i_wr_to_candidate(pl[8]),
    .i_verify_ok(vok), .i_fmt_4k(f4k), .i_run_len(rlen),
    .o_busy_flag(busy), .o_data_request_flag(data_request_flag), .o_ready(rdy),
    .o_interrupt_request_line(irq), .o_abort(abort), .o_queue_halt(qhalt),
    .o_preserve_en(pres), .o_max28(max28), .o_id_word83(w83), .o_id_maxlba(mlba),
    .o_sector_count(scnt), .o_log_valid(lv), .o_log_data_page(ldp),
    .o_log_action_sel(lsel), .o_log_wcache_sel(lwc), .o_log_temp_sel(ltp),
    .o_report_err(rerr), .o_realloc(rall), .o_reassign_en(reas), .o_settings(oset));
  dclc_host_model host (
    .i_sys_clk(clk), .i_rst(rst), .i_busy(busy), .i_drq(data_request_flag), .i_ready(rdy),
    .i_queue_empty(qemp), .i_go(go), .i_break(brk), .i_cmd(hcmd), .i_act(hact),
    .i_feat(hfeat), .o_cmd_wr(cwr), .o_cmd(cmd), .o_act(act), .o_feat(feat));

  always #5 clk = ~clk;
  // =========================================
  // helpers
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // generous ceiling: the spare drain dominates at about 4500 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("MISMATCH %0t run did not finish", $time);
      tally_and_finish();
    end
  end
  task automatic tk(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    pl[b] <= 1'b1;
    @(posedge clk);
    pl[b] <= 1'b0;
    #1;
  endtask
  task automatic ev(input int b);
    r = 1'b0;
    e = 1'b0;
    pulse(b);
    repeat (4) begin
      tk(1);
      r = r | rall;
      e = e | rerr;
    end
    rc += int'(r);
  endtask
  task automatic issue(input logic [7:0] op, ft, input logic [2:0] fl,
                       input logic [15:0] cn, a, f);
    @(posedge clk);
    go <= 1'b1;
    hcmd <= {op, ft, fl, cn};
    hact <= a;
    hfeat <= f;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (int i = 0; i < 40 && !cwr; i++) tk(1);
    chk(cwr, 1'b1, "command not sent");
  endtask
  task automatic wb();
    for (int i = 0; i < 3 && !busy; i++) tk(1);
    chk(busy, 1'b1, "busy after accept");
    for (int i = 0; i < 40 && busy; i++) tk(1);
  endtask
  task automatic nd(input logic [7:0] op, ft, input logic [2:0] fl,
                    input logic [15:0] cn, a, f);
    issue(op, ft, fl, cn, a, f);
    wb();
    chk({busy, data_request_flag}, 2'b00, "idle after busy");
    chk(irq, 1'b1, "interrupt on busy drop");
  endtask
  // =========================================
  // scenarios
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    tk(2);
    chk({rdy, pres, reas, irq}, 4'b1110, "reset state");
    chk(w83[10], 1'b1, "lba48 support");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      nmax <= nm[i];
      tk(3);
      chk(max28, (nm[i] > DCLC_MAX28) ? DCLC_MAX28 : nm[i], "max28");
    end
    nd(8'hE7, 8'h00, 3'b000, 16'h0000, 16'h0000, 16'h0000);
    tk(4);
    chk(irq, 1'b1, "interrupt held");
    pulse(0);
    tk(1);
    chk(irq, 1'b0, "status read clears");
    nd(8'hE7, 8'h00, 3'b000, 16'h0000, 16'h0000, 16'h0000);
    pulse(3);
    tk(1);
    chk(irq, 1'b0, "soft reset clears");
    nd(8'hE7, 8'h00, 3'b000, 16'h0000, 16'h0000, 16'h0000);
    issue(8'hE7, 8'h00, 3'b000, 16'h0000, 16'h0000, 16'h0000);
    tk(1);
    chk(irq, 1'b0, "command write clears");
    wb();
    // data phase keeps the handshake covered
    @(posedge clk);
    xneed <= 1'b1;
    issue(8'h20, 8'h00, 3'b010, 16'h0001, 16'h0000, 16'h0000);
    wb();
    tk(3);
    chk({busy, data_request_flag}, 2'b01, "data request held");
    @(posedge clk);
    xneed <= 1'b0;
    pulse(1);
    for (int i = 0; i < 40 && (busy || data_request_flag); i++) tk(1);
    chk({busy, data_request_flag}, 2'b00, "data command done");
    for (int i = 0; i < 4; i++) begin
      nd(cfl[i][2] ? 8'h25 : 8'hC8, 8'h00, cfl[i], ccn[i], 16'h0000, 16'h0000);
      chk(scnt, cfl[i][2] ? ccn[i] : (ccn[i][7:0] == 8'h00) ? 16'h0100 :
          {8'h00, ccn[i][7:0]}, "sector count");
    end
    @(posedge clk);
    sset <= SV;
    pulse(4);
    pulse(2);
    tk(1);
    chk({oset, irq}, {SV, 1'b0}, "kept over link reset");
    chk(mlba, {16'h0000, SV.max_capacity}, "max lba words");
    nd(DCLC_CMD_SET_FEATURES, DCLC_SF_PRESERVE_DIS, 3'b000, 16'h0, 16'h0, 16'h0);
    chk(pres, 1'b0, "preserve off");
    pulse(2);
    tk(1);
    chk(oset, 94'h0, "cleared over link reset");
    nd(DCLC_CMD_SET_FEATURES, DCLC_SF_PRESERVE_EN, 3'b000, 16'h0, 16'h0, 16'h0);
    chk(pres, 1'b1, "preserve on");
    pulse(4);
    @(posedge clk);
    qemp <= 1'b0;
    nd(8'h60, 8'h00, 3'b111, 16'h0008, 16'h0000, 16'h0000);
    @(posedge clk);
    brk <= 1'b1;
    issue(8'hE7, 8'h00, 3'b000, 16'h0000, 16'h0000, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      tk(1);
      na += int'(abort);
    end
    chk({na[1:0], busy, qhalt}, 4'b0101, "legacy refused in queue");
    @(posedge clk);
    brk <= 1'b0;
    qemp <= 1'b1;
    tk(3);
    chk(qhalt, 1'b0, "halt released");
    for (int i = 0; i < 6; i++) begin
      nd(8'h2F, lp[i], 3'b000, 16'h0001, la[i], lf[i]);
      le = {lp[i] == DCLC_LOG_CMD_PAGE, lp[i] == DCLC_LOG_DATA_PAGE,
            (la[i] >= 16'h0002 && la[i] <= 16'h0005) ? la[i][2:0] : 3'h0,
            la[i] == DCLC_ACT_FEATURE && lf[i] == DCLC_FEAT_WCACHE,
            la[i] == DCLC_ACT_FEATURE && lf[i] == DCLC_FEAT_TEMP_INT};
      chk({lv, ldp, lsel, lwc, ltp}, le, "log decode");
    end
    ev(7);
    chk(r, 1'b1, "recovered read reallocates");
    ev(6);
    chk(r, 1'b0, "hard read only marks");
    @(posedge clk);
    vok <= 1'b0;
    ev(8);
    chk(r, 1'b0, "failed verify keeps sector");
    @(posedge clk);
    vok <= 1'b1;
    ev(8);
    chk(r, 1'b0, "write off candidate");
    ev(6);
    ev(8);
    chk(r, 1'b1, "candidate write reallocates");
    ev(5);
    chk({r, e}, 2'b10, "cached write failure silent");
    @(posedge clk);
    f4k <= 1'b1;
    rlen <= 9'h1FF;
    ev(5);
    @(posedge clk);
    f4k <= 1'b0;
    ev(5);
    @(posedge clk);
    rlen <= 9'h001;
    for (n = 0; n < 1100 && reas; n++) ev(5);
    // 1024 spares less three singles and clipped runs of 32 and 256
    chk({rc[11:0], reas}, {12'h2E2, 1'b0}, "spares exhausted");
    chk(oset.wcache_en, 1'b0, "cache forced off");
    ev(5);
    chk({r, e}, 2'b01, "uncached failed reallocation");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== verilog/dclc_pkg.sv
// package: constants and carriers for the disk command layer control
`default_nettype none
package dclc_pkg;
  // =========================================
  // addressing
  localparam logic [47:0] DCLC_MAX28 = 48'h0000_0FFF_FFFF;
  localparam int DCLC_ID_W83_LBA48_BIT = 10;
  localparam int DCLC_ID_WORD_LBA48 = 83;
  localparam int DCLC_ID_WORD_MAXLBA_LO = 100;
  localparam int DCLC_ID_WORD_MAXLBA_HI = 103;
  // =========================================
  // command codes
  localparam logic [7:0] DCLC_CMD_SET_FEATURES = 8'h00EF;
  localparam logic [7:0] DCLC_SF_PRESERVE_EN = 8'h0086;
  localparam logic [7:0] DCLC_SF_PRESERVE_DIS = 8'h0006;
  localparam logic [7:0] DCLC_LOG_CMD_PAGE = 8'h00E0;
  localparam logic [7:0] DCLC_LOG_DATA_PAGE = 8'h00E1;
  localparam logic [15:0] DCLC_ACT_WRITE_SAME = 16'h0002;
  localparam logic [15:0] DCLC_ACT_ERR_RECOV = 16'h0003;
  localparam logic [15:0] DCLC_ACT_FEATURE = 16'h0004;
  localparam logic [15:0] DCLC_ACT_DATA_TABLE = 16'h0005;
  localparam logic [15:0] DCLC_FEAT_WCACHE = 16'h0001;
  localparam logic [15:0] DCLC_FEAT_TEMP_INT = 16'h0003;
  // =========================================
  // spare and reassignment
  localparam logic [8:0] DCLC_RUN_MAX_512 = 9'h0100;
  localparam logic [8:0] DCLC_RUN_MAX_4K = 9'h0020;
  localparam logic [15:0] DCLC_SPARE_WC_OFF = 16'h0010;
  localparam logic [15:0] DCLC_SPARE_RESET = 16'h0400;
  // =========================================
  // timing
  localparam int DCLC_CLK_MHZ = 100;
  localparam int DCLC_BUSY_NS = 50;
  localparam int DCLC_BUSY_CYC = (DCLC_BUSY_NS * DCLC_CLK_MHZ + 999) / 1000;

  // command as delivered by the host side
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] feature;
    logic is_48bit;
    logic is_lba;
    logic is_queued;
    logic [15:0] count;
  } dclc_cmd_t;

  // preserved software settings
  typedef struct packed {
    logic [15:0] geometry;
    logic [7:0] standby_timer;
    logic sec_frozen;
    logic sec_unlocked;
    logic [47:0] max_capacity;
    logic wcache_en;
    logic [7:0] xfer_mode;
    logic apm_en;
    logic lookahead_en;
    logic revert_def;
    logic [7:0] multi_size;
  } dclc_settings_t;
endpackage
`default_nettype wire

// ===== verilog/dclc_spare.sv
// spare sector bookkeeping and reassignment decisions
`default_nettype none
module dclc_spare
  import dclc_pkg::*;
#(
  parameter logic [15:0] SPARE_INIT = DCLC_SPARE_RESET
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // media events
  input wire logic i_wr_fail,
  input wire logic i_rd_hard_fail,
  input wire logic i_rd_recovered,
  input wire logic i_wr_to_candidate,
  input wire logic i_verify_ok,
  input wire logic i_fmt_4k,
  input wire logic [8:0] i_run_len,
  input wire logic i_wcache_en,
  // results
  output logic [15:0] o_spare_cnt,
  output logic o_reassign_en,
  output logic o_wc_force_off,
  output logic o_realloc,
  output logic o_report_err,
  output logic o_candidate
);
  logic [8:0] run_max;
  logic want;
  logic [15:0] need;

  assign run_max = i_fmt_4k ? DCLC_RUN_MAX_4K : DCLC_RUN_MAX_512;
  // clip the run to one table entry
  assign need = {7'h00, (i_run_len > run_max) ? run_max : i_run_len};
  // a write earns a reallocation if it fails, or if it hits a marked location while i_verify_ok is high
  assign want = i_wr_fail | i_rd_recovered | (i_wr_to_candidate & o_candidate & i_verify_ok);

  // =========================================
  // spare count; power-on reset only, table survives link resets
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_spare_cnt <= SPARE_INIT;
      o_realloc <= 1'b0;
      o_report_err <= 1'b0;
    end else begin
      o_realloc <= 1'b0;
      o_report_err <= 1'b0;
      if (want && o_reassign_en && o_spare_cnt >= need) begin
        o_spare_cnt <= o_spare_cnt - need;
        o_realloc <= 1'b1;
      end else if (i_wr_fail && !i_wcache_en) begin
        o_report_err <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_candidate <= 1'b0;
    end else if (i_rd_hard_fail) begin
      o_candidate <= 1'b1;
    end else if (i_wr_to_candidate) begin
      o_candidate <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_reassign_en <= 1'b1;
      o_wc_force_off <= 1'b0;
    end else begin
      o_reassign_en <= (o_spare_cnt != 16'h0000);
      o_wc_force_off <= (o_spare_cnt <= DCLC_SPARE_WC_OFF);
    end
  end

  a_spare_zero_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_spare_cnt == 16'h0000) |=> !o_reassign_en)
    else $error("reassign not disabled at zero spares");
  a_wc_low_spare: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (o_spare_cnt <= DCLC_SPARE_WC_OFF) |=> o_wc_force_off)
    else $error("write cache not forced off");
  a_err_only_wc_off: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    o_report_err |-> $past(!i_wcache_en) && $past(i_wr_fail))
    else $error("write error reported with cache on");
endmodule
`default_nettype wire

// ===== verilog/dclc_top.sv
// command layer control: status handshake, addressing, settings, queue guard
`default_nettype none
// Summary of operation
// - 28-bit native max saturates at 268435455
// - advertise 48-bit support and max LBA
// - 48-bit LBA only; 28/48 may intermix
// - 48-bit sector count is 16 bits
// - preservation enable via feature 86h, disable via 06h, default on
// - preserved settings kept or cleared on link reset
// - legacy during queue aborts and halts queue
// - log page E0h commands, E1h data
// - recognise transport actions 0002h to 0005h
// - feature codes 0001h cache, 0003h temperature
// - busy or data request held until done
// - interrupt on busy falling during command
// - interrupt cleared by status read, reset, command
// - entry run limit 256 or 32, retained
// - reassign disabled at zero spares
// - write cache off at 16 spares
// - failed write reallocates; error only if uncached
// - hard read error marks reallocation candidate
// - recovered read reallocates sector
module dclc_top
  import dclc_pkg::*;
#(
  parameter int BUSY_CYC = DCLC_BUSY_CYC
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_link_rst,
  input wire logic i_soft_rst,
  // host command register side
  input wire logic i_cmd_wr,
  input wire dclc_cmd_t i_cmd,
  input wire logic [15:0] i_log_action,
  input wire logic [15:0] i_log_feature,
  input wire logic i_status_rd,
  input wire logic [47:0] i_native_max,
  // execution engine
  input wire logic i_xfer_need,
  input wire logic i_xfer_done,
  input wire logic i_queue_empty,
  input wire logic i_settings_wr,
  input wire dclc_settings_t i_settings,
  // media events
  input wire logic i_wr_fail,
  input wire logic i_rd_hard_fail,
  input wire logic i_rd_recovered,
  input wire logic i_wr_to_candidate,
  input wire logic i_verify_ok,
  input wire logic i_fmt_4k,
  input wire logic [8:0] i_run_len,
  // status
  output logic o_busy_flag,
  output logic o_data_request_flag,
  output logic o_ready,
  output logic o_interrupt_request_line,
  output logic o_abort,
  output logic o_queue_halt,
  output logic o_preserve_en,
  output logic [47:0] o_max28,
  output logic [15:0] o_id_word83,
  output logic [63:0] o_id_maxlba,
  output logic [15:0] o_sector_count,
  output logic o_log_valid,
  output logic o_log_data_page,
  output logic [2:0] o_log_action_sel,
  output logic o_log_wcache_sel,
  output logic o_log_temp_sel,
  output logic o_report_err,
  output logic o_realloc,
  output logic o_reassign_en,
  output dclc_settings_t o_settings
);
  typedef enum logic [1:0] {
    DCLC_IDLE = 2'b00,
    DCLC_BUSY = 2'b01,
    DCLC_XFER = 2'b10
  } dclc_state_t;

  dclc_state_t state_q;
  logic [7:0] busy_cnt_q;
  logic busy_fall;
  logic legacy_in_queue;
  logic any_rst;
  logic [15:0] spare_cnt;
  logic wc_force_off;
  logic candidate;
  logic realloc_w;
  logic report_err_w;
  logic reassign_en_w;

  assign any_rst = i_rst | i_link_rst | i_soft_rst;
  assign legacy_in_queue = i_cmd_wr && !i_cmd.is_queued && !i_queue_empty;
  assign busy_fall = (state_q == DCLC_BUSY) && (busy_cnt_q == 8'h00) && !i_xfer_need;

  // =========================================
  // command phase; busy set on acceptance, released only into xfer or done
  always_ff @(posedge i_sys_clk) begin
    if (any_rst) begin
      state_q <= DCLC_IDLE;
      busy_cnt_q <= 8'h00;
    end else begin
      unique case (state_q)
        DCLC_IDLE: begin
          if (i_cmd_wr && !legacy_in_queue) begin
            state_q <= DCLC_BUSY;
            busy_cnt_q <= 8'(BUSY_CYC);
          end
        end
        DCLC_BUSY: begin
          if (busy_cnt_q != 8'h00) begin
            busy_cnt_q <= busy_cnt_q - 8'h01;
          end else if (i_xfer_need) begin
            state_q <= DCLC_XFER;
          end else begin
            state_q <= DCLC_IDLE;
          end
        end
        DCLC_XFER: begin
          if (i_xfer_done) begin
            state_q <= DCLC_BUSY;
            busy_cnt_q <= 8'(BUSY_CYC);
          end
        end
        default: state_q <= DCLC_IDLE;
      endcase
    end
  end

  // flags follow the next state so neither gap ever shows
  always_ff @(posedge i_sys_clk) begin
    if (any_rst) begin
      o_busy_flag <= 1'b0;
      o_data_request_flag <= 1'b0;
      o_ready <= 1'b0;
    end else begin
      o_ready <= 1'b1;
      o_busy_flag <= (state_q == DCLC_IDLE && i_cmd_wr && !legacy_in_queue)
        || (state_q == DCLC_BUSY && !(busy_cnt_q == 8'h00))
        || (state_q == DCLC_XFER && i_xfer_done);
      o_data_request_flag <= (state_q == DCLC_BUSY && busy_cnt_q == 8'h00 && i_xfer_need)
        || (state_q == DCLC_XFER && !i_xfer_done);
    end
  end

  // =========================================
  // interrupt: set wins over a status read or command write clear in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (any_rst) begin
      o_interrupt_request_line <= 1'b0;
    end else if (busy_fall) begin
      o_interrupt_request_line <= 1'b1;
    end else if (i_status_rd || i_cmd_wr) begin
      o_interrupt_request_line <= 1'b0;
    end
  end

  // =========================================
  // queue guard
  always_ff @(posedge i_sys_clk) begin
    if (any_rst) begin
      o_abort <= 1'b0;
      o_queue_halt <= 1'b0;
    end else begin
      o_abort <= legacy_in_queue;
      if (legacy_in_queue) begin
        o_queue_halt <= 1'b1;
      end else if (i_queue_empty) begin
        o_queue_halt <= 1'b0;
      end
    end
  end

  // =========================================
  // addressing and identify words
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_max28 <= 48'h0000_0000_0000;
      o_id_word83 <= 16'h0000;
      o_id_maxlba <= 64'h0000_0000_0000_0000;
      o_sector_count <= 16'h0000;
    end else begin
      o_max28 <= (i_native_max > DCLC_MAX28) ? DCLC_MAX28 : i_native_max;
      o_id_word83 <= 16'h0001 << DCLC_ID_W83_LBA48_BIT;
      o_id_maxlba <= {16'h0000, o_settings.max_capacity};
      if (i_cmd_wr) begin
        // 28-bit commands keep the legacy 8-bit count, zero meaning 256
        if (i_cmd.is_48bit && i_cmd.is_lba) begin
          o_sector_count <= i_cmd.count;
        end else begin
          o_sector_count <= (i_cmd.count[7:0] == 8'h00) ? 16'h0100 : {8'h00, i_cmd.count[7:0]};
        end
      end
    end
  end

  // =========================================
  // settings preservation
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_preserve_en <= 1'b1;
    end else if (i_cmd_wr && i_cmd.opcode == DCLC_CMD_SET_FEATURES) begin
      if (i_cmd.feature == DCLC_SF_PRESERVE_EN) begin
        o_preserve_en <= 1'b1;
      end else if (i_cmd.feature == DCLC_SF_PRESERVE_DIS) begin
        o_preserve_en <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_settings <= '0;
    end else if (i_link_rst && !o_preserve_en) begin
      o_settings <= '0;
    end else begin
      // other settings stay writable while the cache is forced off
      if (i_settings_wr) begin
        o_settings <= i_settings;
      end
      if (wc_force_off) begin
        o_settings.wcache_en <= 1'b0;
      end
    end
  end

  // =========================================
  // log command transport decode
  always_ff @(posedge i_sys_clk) begin
    if (any_rst) begin
      o_log_valid <= 1'b0;
      o_log_data_page <= 1'b0;
      o_log_action_sel <= 3'h0;
      o_log_wcache_sel <= 1'b0;
      o_log_temp_sel <= 1'b0;
    end else if (i_cmd_wr) begin
      o_log_valid <= (i_cmd.feature == DCLC_LOG_CMD_PAGE);
      o_log_data_page <= (i_cmd.feature == DCLC_LOG_DATA_PAGE);
      o_log_action_sel <= (i_log_action == DCLC_ACT_WRITE_SAME) ? 3'h2 :
        (i_log_action == DCLC_ACT_ERR_RECOV) ? 3'h3 :
        (i_log_action == DCLC_ACT_FEATURE) ? 3'h4 :
        (i_log_action == DCLC_ACT_DATA_TABLE) ? 3'h5 : 3'h0;
      o_log_wcache_sel <= (i_log_action == DCLC_ACT_FEATURE)
        && (i_log_feature == DCLC_FEAT_WCACHE);
      o_log_temp_sel <= (i_log_action == DCLC_ACT_FEATURE)
        && (i_log_feature == DCLC_FEAT_TEMP_INT);
    end
  end

  // =========================================
  // spare bookkeeping
  dclc_spare u_spare (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_wr_fail(i_wr_fail),
    .i_rd_hard_fail(i_rd_hard_fail),
    .i_rd_recovered(i_rd_recovered),
    .i_wr_to_candidate(i_wr_to_candidate),
    .i_verify_ok(i_verify_ok),
    .i_fmt_4k(i_fmt_4k),
    .i_run_len(i_run_len),
    .i_wcache_en(o_settings.wcache_en),
    .o_spare_cnt(spare_cnt),
    .o_reassign_en(reassign_en_w),
    .o_wc_force_off(wc_force_off),
    .o_realloc(realloc_w),
    .o_report_err(report_err_w),
    .o_candidate(candidate)
  );

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_realloc <= 1'b0;
      o_report_err <= 1'b0;
      o_reassign_en <= 1'b1;
    end else begin
      o_realloc <= realloc_w;
      o_report_err <= report_err_w;
      o_reassign_en <= reassign_en_w;
    end
  end

  // =========================================
  // checks
  sequence s_accept;
    state_q == DCLC_IDLE && i_cmd_wr && !legacy_in_queue;
  endsequence

  a_accept_busy: assert property (@(posedge i_sys_clk) disable iff (any_rst)
    s_accept |=> o_busy_flag)
    else $error("busy not set on accept");
  a_flag_cover: assert property (@(posedge i_sys_clk) disable iff (any_rst)
    (state_q != DCLC_IDLE) |-> (o_busy_flag || o_data_request_flag))
    else $error("neither busy nor data request during command");
  a_irq_on_fall: assert property (@(posedge i_sys_clk) disable iff (any_rst)
    busy_fall |=> o_interrupt_request_line)
    else $error("no interrupt on busy release");
  a_irq_clear: assert property (@(posedge i_sys_clk) disable iff (any_rst)
    (i_status_rd && !busy_fall) |=> !o_interrupt_request_line)
    else $error("interrupt not cleared by status read");
  a_irq_hold: assert property (@(posedge i_sys_clk) disable iff (any_rst)
    (o_interrupt_request_line && !i_status_rd && !i_cmd_wr) |=> o_interrupt_request_line)
    else $error("pending interrupt lost");
  a_max28_sat: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_native_max > DCLC_MAX28) |=> (o_max28 == DCLC_MAX28))
    else $error("28-bit max not saturated");
  a_legacy_abort: assert property (@(posedge i_sys_clk) disable iff (any_rst)
    legacy_in_queue |=> (o_abort && o_queue_halt && !o_busy_flag))
    else $error("legacy command during queue not aborted");
  a_preserve_sf: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_cmd_wr && i_cmd.opcode == DCLC_CMD_SET_FEATURES && i_cmd.feature == DCLC_SF_PRESERVE_DIS)
    |=> !o_preserve_en)
    else $error("preservation not disabled");
  a_clear_on_link: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (i_link_rst && !o_preserve_en) |=> (o_settings == '0))
    else $error("settings not cleared on link reset");
  a_cache_low_spare: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (spare_cnt <= DCLC_SPARE_WC_OFF) |=> ##1 !o_settings.wcache_en)
    else $error("write cache setting not forced off");
  a_hard_read_mark: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    i_rd_hard_fail |=> candidate)
    else $error("hard read error not marked");
endmodule
`default_nettype wire
